// ===== hdl/psmc_consts.vh
// Purpose: Constants for the power saving mode controller
// Assumes: 32-bit AHB-Lite register words
// Notes:   Offsets are byte addresses
`ifndef PSMC_CONSTS_VH
`define PSMC_CONSTS_VH
`define PSMC_OFF_PWRCTL   12'h000
`define PSMC_OFF_PLLCTL   12'h004
`define PSMC_OFF_STATUS   12'h008
`define PSMC_OFF_IRQSTAT  12'h00c
`define PSMC_OFF_IRQEN    12'h010
`define PSMC_OFF_IRQCLR   12'h014
`define PSMC_BIT_IDLE     0
`define PSMC_BIT_PDOWN    1
`define PSMC_BIT_SERWAKE  2
`define PSMC_BIT_INT0WAKE 3
`define PSMC_BIT_OSCPD    0
`define PSMC_BIT_TICEN    1
`define PSMC_PWRCTL_RST   4'h0
`define PSMC_PLLCTL_RST   2'h0
`define PSMC_MODE_RUN     2'h0
`define PSMC_MODE_IDLE    2'h1
`define PSMC_MODE_PDOWN   2'h2
`define PSMC_EV_IDLE      0
`define PSMC_EV_PDOWN     1
`define PSMC_EV_WAKE      2
`define PSMC_TIC_RELOAD   16'h0014
`endif

// ===== hdl/psmc_sync.v
// Purpose: Two flip-flop synchroniser for one level
// Assumes: Input may be asynchronous to clock_i
// Notes:   First stage feeds only the second
`timescale 1ns/1ns
`default_nettype none
module psmc_sync (
  input  wire clock_i,
  input  wire sys_rst_i,
  input  wire d_i,
  output reg  q_o
);
  reg meta_reg;
  always @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      meta_reg <= 1'b0;
      q_o      <= 1'b0;
    end else begin
      meta_reg <= d_i;
      q_o      <= meta_reg;
    end
  end
endmodule // psmc_sync
`default_nettype wire

// ===== hdl/psmc_tic.v
// Purpose: Time interval counter on the oscillator tick
// Assumes: tick_i is a one-cycle enable from the oscillator divider
// Notes:   Keeps counting in power-down when enabled, unless the oscillator is powered down (OSCPD), which stops the tick
`timescale 1ns/1ns
`default_nettype none
module psmc_tic #(
  parameter W = 16
) (
  input  wire         clock_i,
  input  wire         sys_rst_i,
  input  wire         tick_i,
  input  wire         enable_i,
  input  wire [W-1:0] reload_i,
  output reg          expire_o
);
  reg [W-1:0] count_reg;
  always @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      count_reg <= {W{1'b0}};
      expire_o  <= 1'b0;
    end else begin
      expire_o <= 1'b0;
      if (!enable_i) begin
        count_reg <= reload_i;
      end else if (tick_i) begin
        if (count_reg == {W{1'b0}}) begin
          count_reg <= reload_i;
          expire_o  <= 1'b1;
        end else begin
          count_reg <= count_reg - {{(W-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule // psmc_tic
`default_nettype wire

// ===== hdl/psmc_top.v
// Purpose: Power saving mode controller with AHB-Lite registers
// Assumes: Core, peripherals and pads act on the enables driven here
// Notes:   Implementer's choices follow
//
// The implementer's own choices: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "psmc_consts.vh"
module psmc_top #(
  parameter OSC_DIV = 610
) (
  input  wire        clock_i,
  input  wire        sys_rst_i,
  input  wire        hsel,
  input  wire [11:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  input  wire        irq_pending_i,
  input  wire        serial_irq_i,
  input  wire        external_interrupt_zero_i,
  input  wire        core_strobe_addr_i,
  input  wire        program_store_strobe_i,
  output reg         core_clk_en_o,
  output reg         periph_clk_en_o,
  output reg         pll_en_o,
  output reg         osc_en_o,
  output reg         pin_hold_o,
  output reg         dac_hiz_o,
  output reg         addr_latch_strobe_o,
  output reg         program_store_strobe_o,
  output reg         tic_irq_o,
  output reg         irq_o
);
  reg  [3:0]  power_control_reg;
  reg  [1:0]  pll_control_reg;
  reg  [1:0]  mode_reg;
  reg  [2:0]  irq_stat_reg;
  reg  [2:0]  irq_en_reg;
  reg         dph_wr_reg;
  reg         dph_rd_reg;
  reg  [11:0] dph_addr_reg;
  reg  [9:0]  osc_div_reg;
  reg         osc_tick_reg;
  reg  [1:0]  mode_next;
  reg  [2:0]  ev_set;
  wire        serial_sync;
  wire        external_interrupt_zero_sync;
  wire        tic_expire;
  wire        addr_ok;
  wire        wake_pd;
  wire        wake_idle;
  wire        pd_req;
  wire        idle_req;
  wire        wr_pwrctl;

  psmc_sync u_sync_ser (
    .clock_i   (clock_i),
    .sys_rst_i (sys_rst_i),
    .d_i       (serial_irq_i),
    .q_o       (serial_sync)
  );
  psmc_sync u_sync_external_interrupt_zero (
    .clock_i   (clock_i),
    .sys_rst_i (sys_rst_i),
    .d_i       (external_interrupt_zero_i),
    .q_o       (external_interrupt_zero_sync)
  );

  // Oscillator-rate tick; stops when oscillator is halted
  always @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      osc_div_reg  <= 10'h000;
      osc_tick_reg <= 1'b0;
    end else if (!osc_en_o) begin
      osc_div_reg  <= 10'h000;
      osc_tick_reg <= 1'b0;
    end else if (osc_div_reg == OSC_DIV[9:0] - 10'h001) begin
      osc_div_reg  <= 10'h000;
      osc_tick_reg <= 1'b1;
    end else begin
      osc_div_reg  <= osc_div_reg + 10'h001;
      osc_tick_reg <= 1'b0;
    end
  end

  psmc_tic #(
    .W (16)
  ) u_tic (
    .clock_i   (clock_i),
    .sys_rst_i (sys_rst_i),
    .tick_i    (osc_tick_reg),
    .enable_i  (pll_control_reg[`PSMC_BIT_TICEN]),
    .reload_i  (`PSMC_TIC_RELOAD),
    .expire_o  (tic_expire)
  );

  // Bus address and data phase
  assign addr_ok   = hsel && hready && htrans[1];
  assign wr_pwrctl = dph_wr_reg && (dph_addr_reg == `PSMC_OFF_PWRCTL);
  assign pd_req    = wr_pwrctl && hwdata[`PSMC_BIT_PDOWN];
  assign idle_req  = wr_pwrctl && hwdata[`PSMC_BIT_IDLE];

  assign wake_pd   = tic_expire
                   || (serial_sync && power_control_reg[`PSMC_BIT_SERWAKE])
                   || (external_interrupt_zero_sync && power_control_reg[`PSMC_BIT_INT0WAKE]);
  assign wake_idle = irq_pending_i || wake_pd;

  always @* begin
    mode_next = mode_reg;
    case (mode_reg)
      `PSMC_MODE_RUN: begin
        if (pd_req) begin
          mode_next = `PSMC_MODE_PDOWN;
        end else if (idle_req) begin
          mode_next = `PSMC_MODE_IDLE;
        end
      end
      `PSMC_MODE_IDLE: begin
        if (wake_idle) begin
          mode_next = `PSMC_MODE_RUN;
        end
      end
      `PSMC_MODE_PDOWN: begin
        if (wake_pd) begin
          mode_next = `PSMC_MODE_RUN;
        end
      end
      default: begin
        mode_next = `PSMC_MODE_RUN;
      end
    endcase
  end

  always @* begin
    ev_set = 3'h0;
    ev_set[`PSMC_EV_IDLE]  = (mode_reg != `PSMC_MODE_IDLE) && (mode_next == `PSMC_MODE_IDLE);
    ev_set[`PSMC_EV_PDOWN] = (mode_reg != `PSMC_MODE_PDOWN) && (mode_next == `PSMC_MODE_PDOWN);
    ev_set[`PSMC_EV_WAKE]  = (mode_reg != `PSMC_MODE_RUN) && (mode_next == `PSMC_MODE_RUN);
  end

  // Reset pin high clears every register to default
  always @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      mode_reg          <= `PSMC_MODE_RUN;
      power_control_reg <= `PSMC_PWRCTL_RST;
      pll_control_reg   <= `PSMC_PLLCTL_RST;
      irq_stat_reg      <= 3'h0;
      irq_en_reg        <= 3'h0;
      dph_wr_reg        <= 1'b0;
      dph_rd_reg        <= 1'b0;
      dph_addr_reg      <= 12'h000;
    end else begin
      mode_reg     <= mode_next;
      dph_wr_reg   <= addr_ok && hwrite;
      dph_rd_reg   <= addr_ok && !hwrite;
      dph_addr_reg <= {haddr[11:2], 2'b00};
      if (mode_next == `PSMC_MODE_RUN) begin
        power_control_reg[1:0] <= 2'b00;
      end else begin
        power_control_reg[1:0] <= (mode_next == `PSMC_MODE_PDOWN) ? 2'b10 : 2'b01;
      end
      if (wr_pwrctl) begin
        power_control_reg[3:2] <= hwdata[3:2];
      end
      if (dph_wr_reg && dph_addr_reg == `PSMC_OFF_PLLCTL) begin
        pll_control_reg <= hwdata[1:0];
      end
      if (dph_wr_reg && dph_addr_reg == `PSMC_OFF_IRQEN) begin
        irq_en_reg <= hwdata[2:0];
      end
      // Hardware set wins over software clear
      if (dph_wr_reg && dph_addr_reg == `PSMC_OFF_IRQCLR) begin
        irq_stat_reg <= (irq_stat_reg & ~hwdata[2:0]) | ev_set;
      end else begin
        irq_stat_reg <= irq_stat_reg | ev_set;
      end
    end
  end

  // Read data and zero-wait responses
  always @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h0000_0000;
      if (addr_ok && !hwrite) begin
        case ({haddr[11:2], 2'b00})
          `PSMC_OFF_PWRCTL:  hrdata <= {28'h0, power_control_reg};
          `PSMC_OFF_PLLCTL:  hrdata <= {30'h0, pll_control_reg};
          `PSMC_OFF_STATUS:  hrdata <= {30'h0, mode_reg};
          `PSMC_OFF_IRQSTAT: hrdata <= {29'h0, irq_stat_reg};
          `PSMC_OFF_IRQEN:   hrdata <= {29'h0, irq_en_reg};
          default:           hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Clock, pad and strobe controls per mode
  always @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      core_clk_en_o          <= 1'b1;
      periph_clk_en_o        <= 1'b1;
      pll_en_o               <= 1'b1;
      osc_en_o               <= 1'b1;
      pin_hold_o             <= 1'b0;
      dac_hiz_o              <= 1'b0;
      addr_latch_strobe_o    <= 1'b1;
      program_store_strobe_o <= 1'b1;
      tic_irq_o              <= 1'b0;
      irq_o                  <= 1'b0;
    end else begin
      tic_irq_o <= tic_expire;
      irq_o     <= |(irq_stat_reg & irq_en_reg);
      case (mode_next)
        `PSMC_MODE_IDLE: begin
          core_clk_en_o          <= 1'b0;
          periph_clk_en_o        <= 1'b1;
          pll_en_o               <= 1'b1;
          osc_en_o               <= 1'b1;
          pin_hold_o             <= 1'b1;
          dac_hiz_o              <= 1'b0;
          addr_latch_strobe_o    <= 1'b1;
          program_store_strobe_o <= 1'b1;
        end
        `PSMC_MODE_PDOWN: begin
          core_clk_en_o          <= 1'b0;
          periph_clk_en_o        <= 1'b0;
          pll_en_o               <= 1'b0;
          osc_en_o               <= !pll_control_reg[`PSMC_BIT_OSCPD];
          pin_hold_o             <= 1'b1;
          dac_hiz_o              <= 1'b1;
          addr_latch_strobe_o    <= 1'b0;
          program_store_strobe_o <= 1'b0;
        end
        default: begin
          core_clk_en_o          <= 1'b1;
          periph_clk_en_o        <= 1'b1;
          pll_en_o               <= 1'b1;
          osc_en_o               <= 1'b1;
          pin_hold_o             <= 1'b0;
          dac_hiz_o              <= 1'b0;
          addr_latch_strobe_o    <= core_strobe_addr_i;
          program_store_strobe_o <= program_store_strobe_i;
        end
      endcase
    end
  end
endmodule // psmc_top
`default_nettype wire

// ===== tb/psmc_checker.sv
// Purpose: Port assertions for psmc_top
// Assumes: One clock domain
// Notes: Bound at file foot
`timescale 1ns/1ns
`default_nettype none
module psmc_checker (
  input wire clock_i,
  input wire sys_rst_i,
  input wire core_clk_en_o,
  input wire periph_clk_en_o,
  input wire pll_en_o,
  input wire osc_en_o,
  input wire pin_hold_o,
  input wire dac_hiz_o,
  input wire addr_latch_strobe_o,
  input wire program_store_strobe_o,
  input wire tic_irq_o,
  input wire irq_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  sequence s_run; core_clk_en_o && periph_clk_en_o; endsequence
  sequence s_idle; !core_clk_en_o && periph_clk_en_o; endsequence
  sequence s_down; !core_clk_en_o && !periph_clk_en_o; endsequence
  property p_idle; s_idle |-> addr_latch_strobe_o && program_store_strobe_o
    && pin_hold_o && !dac_hiz_o && osc_en_o; endproperty
  a_idle: assert property (p_idle) else $error("idle outputs wrong");
  property p_down; s_down |-> !pll_en_o && pin_hold_o && dac_hiz_o
    && !addr_latch_strobe_o && !program_store_strobe_o; endproperty
  a_down: assert property (p_down) else $error("power-down outputs wrong");
  property p_run; s_run |-> pll_en_o && osc_en_o && !pin_hold_o && !dac_hiz_o; endproperty
  a_run: assert property (p_run) else $error("run outputs wrong");
  property p_reset; disable iff (1'b0) sys_rst_i |-> s_run ##0 (pll_en_o && osc_en_o
    && !pin_hold_o && !dac_hiz_o && !irq_o && addr_latch_strobe_o); endproperty
  a_reset: assert property (p_reset) else $error("reset values wrong");
  property p_tic_pulse; tic_irq_o |=> !tic_irq_o; endproperty
  a_tic_pulse: assert property (p_tic_pulse) else $error("interval pulse too long");
  property p_tic_wake; s_down ##1 tic_irq_o |-> s_run; endproperty
  a_tic_wake: assert property (p_tic_wake) else $error("no wake on interval expiry");
  property p_down_osc; s_down ##1 s_down |-> $stable(osc_en_o); endproperty
  a_down_osc: assert property (p_down_osc) else $error("oscillator changed in power-down");
  property p_wake; $rose(periph_clk_en_o) |-> core_clk_en_o; endproperty
  a_wake: assert property (p_wake) else $error("wake not to run");
endmodule // psmc_checker
bind psmc_top psmc_checker u_chk (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .core_clk_en_o(core_clk_en_o),
  .periph_clk_en_o(periph_clk_en_o), .pll_en_o(pll_en_o), .osc_en_o(osc_en_o), .pin_hold_o(pin_hold_o),
  .dac_hiz_o(dac_hiz_o), .addr_latch_strobe_o(addr_latch_strobe_o),
  .program_store_strobe_o(program_store_strobe_o), .tic_irq_o(tic_irq_o), .irq_o(irq_o));
`default_nettype wire

// ===== tb/psmc_core_model.sv
// Purpose: Core and interrupt source model facing psmc_top
// Assumes: Bench commands each interrupt line
// Notes: Strobes toggle only while the core clock runs
`timescale 1ns/1ns
`default_nettype none
module psmc_core_model (
  input  wire        clock_i,
  input  wire        sys_rst_i,
  input  wire        core_clk_en_i,
  input  wire  [2:0] req_i,
  output logic       irq_pending_o,
  output logic       serial_irq_o,
  output logic       ext_external_interrupt_zero_o,
  output logic       addr_stb_o,
  output logic       prog_stb_o
);
  always @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      {irq_pending_o, serial_irq_o, ext_external_interrupt_zero_o} <= 3'h0;
      {addr_stb_o, prog_stb_o} <= 2'h3;
    end else begin
      irq_pending_o <= req_i[0];
      serial_irq_o <= req_i[1];
      ext_external_interrupt_zero_o <= req_i[2];
      if (core_clk_en_i) begin
        addr_stb_o <= ~addr_stb_o;
        prog_stb_o <= addr_stb_o;
      end
    end
  end
endmodule // psmc_core_model
`default_nettype wire

// ===== tb/tb_top.sv
// Purpose: Self-checking bench for psmc_top
// Assumes: 20 MHz clock, AHB-Lite master tasks
// Notes: OSC_DIV shortened to 4
`timescale 1ns/1ns
`default_nettype none
`include "psmc_consts.vh"
module tb_top;
  logic        clock_i = 0, sys_rst_i = 0, hsel = 0, hwrite = 0, hreadyout, hresp, pend, ser, external_interrupt_zero, sa, sp;
  logic        core_en, per_en, pll_en, osc_en, hold, hiz, sa_o, sp_o, tic, irq_o;
  logic [11:0] haddr = 0;
  logic [1:0]  htrans = 0;
  logic [2:0]  req = 0;
  logic [31:0] hwdata = 0, hrdata, q;
  int          mismatches = 0, samples_checked = 0, n;
  wire  [7:0]  outs = {core_en, per_en, pll_en, osc_en, hold, hiz, sa_o, sp_o};
  psmc_top #(.OSC_DIV(4)) uut (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .irq_pending_i(pend), .serial_irq_i(ser),
    .external_interrupt_zero_i(external_interrupt_zero), .core_strobe_addr_i(sa), .program_store_strobe_i(sp),
    .core_clk_en_o(core_en), .periph_clk_en_o(per_en), .pll_en_o(pll_en), .osc_en_o(osc_en),
    .pin_hold_o(hold), .dac_hiz_o(hiz), .addr_latch_strobe_o(sa_o), .program_store_strobe_o(sp_o),
    .tic_irq_o(tic), .irq_o(irq_o));
  psmc_core_model partner (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .core_clk_en_i(core_en), .req_i(req),
    .irq_pending_o(pend), .serial_irq_o(ser), .ext_external_interrupt_zero_o(external_interrupt_zero), .addr_stb_o(sa), .prog_stb_o(sp));
  initial begin
    forever #25 clock_i = ~clock_i;
  end
  task automatic wt(input int c);
    repeat (c) @(posedge clock_i);
  endtask
  task automatic rst;
    sys_rst_i <= 1'b1;
    wt(6);
    sys_rst_i <= 1'b0;
    wt(1);
  endtask
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    @(posedge clock_i);
    while (hreadyout !== 1'b1) @(posedge clock_i);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clock_i);
    while (hreadyout !== 1'b1) @(posedge clock_i);
    q = hrdata;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), e, q);
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask
  task automatic chko(input logic [7:0] e, input logic [7:0] m);
    chk("mode outputs", {24'h0, e & m}, {24'h0, outs & m});
  endtask
  task automatic t_reset;
    rd(`PSMC_OFF_PWRCTL, 32'h0);
    rd(`PSMC_OFF_PLLCTL, 32'h0);
    rd(`PSMC_OFF_STATUS, 32'h0);
    rd(`PSMC_OFF_IRQEN, 32'h0);
    rd(`PSMC_OFF_IRQSTAT, 32'h0);
    rd(12'h040, 32'h0);
    chko(8'hf0, 8'hfc);
  endtask
  task automatic t_idle;
    bus(1'b1, `PSMC_OFF_IRQEN, 32'h1);
    bus(1'b1, `PSMC_OFF_PWRCTL, 32'h1);
    wt(3);
    chko(8'h5b, 8'hdf);
    rd(`PSMC_OFF_STATUS, 32'h1);
    chk("irq", 32'h1, {31'h0, irq_o});
    bus(1'b1, `PSMC_OFF_IRQCLR, 32'h1);
    wt(3);
    chk("irq", 32'h0, {31'h0, irq_o});
    req <= 3'h1;
    wt(6);
    req <= 3'h0;
    chko(8'hf0, 8'hfc);
    rd(`PSMC_OFF_IRQSTAT, 32'h4);
    chk("irq masked", 32'h0, {31'h0, irq_o});
    bus(1'b1, `PSMC_OFF_IRQCLR, 32'h7);
  endtask
  task automatic t_wake(input logic [2:0] r, input logic [31:0] en);
    bus(1'b1, `PSMC_OFF_PWRCTL, 32'h3);
    wt(3);
    rd(`PSMC_OFF_STATUS, 32'h2);
    chko(8'h1c, 8'hff);
    req <= r;
    wt(10);
    rd(`PSMC_OFF_STATUS, 32'h2);
    req <= 3'h0;
    rst;
    rd(`PSMC_OFF_PWRCTL, 32'h0);
    bus(1'b1, `PSMC_OFF_PWRCTL, en | 32'h2);
    wt(3);
    req <= r;
    wt(10);
    req <= 3'h0;
    rd(`PSMC_OFF_STATUS, 32'h0);
  endtask
  task automatic t_tic;
    bus(1'b1, `PSMC_OFF_PLLCTL, 32'h2);
    bus(1'b1, `PSMC_OFF_PWRCTL, 32'h2);
    wt(3);
    chko(8'h1c, 8'hff);
    for (n = 0; n < 300 && core_en !== 1'b1; n++) @(posedge clock_i);
    rd(`PSMC_OFF_STATUS, 32'h0);
    bus(1'b1, `PSMC_OFF_PLLCTL, 32'h3);
    bus(1'b1, `PSMC_OFF_PWRCTL, 32'h2);
    wt(200);
    chko(8'h0c, 8'hff);
    rst;
    rd(`PSMC_OFF_PLLCTL, 32'h0);
  endtask
  task automatic end_of_test;
    if (mismatches == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #2000000;
    mismatches++;
    end_of_test;
  end
  initial begin
    rst;
    t_reset;
    t_idle;
    t_wake(3'h2, 32'h4);
    t_wake(3'h4, 32'h8);
    t_tic;
    end_of_test;
  end
endmodule // tb_top
`default_nettype wire
